// ### rtl/sms_pkg.sv
// package of constants for the store multiple and single execution block
package sms_pkg;
  // apb register byte offsets
  localparam logic [7:0] SMS_CTRL_OFS = 8'h00;
  localparam logic [7:0] SMS_STAT_OFS = 8'h04;
  localparam logic [7:0] SMS_EXEC_OFS = 8'h08;
  localparam logic [7:0] SMS_SKIP_OFS = 8'h0c;
  localparam logic [7:0] SMS_ADDR_OFS = 8'h10;
  // control fields and reset value
  localparam int SMS_CTRL_EN_BIT = 0;
  localparam int SMS_CTRL_CLR_BIT = 1;
  localparam logic SMS_CTRL_EN_RST = 1'b1;
  // instruction field positions
  localparam int SMS_COND_HI = 31;
  localparam int SMS_COND_LO = 28;
  localparam int SMS_MULT_BIT = 27;
  localparam int SMS_REGOFS_BIT = 25;
  localparam int SMS_PRE_BIT = 24;
  localparam int SMS_UP_BIT = 23;
  localparam int SMS_BYTE_USER_BIT = 22;
  localparam int SMS_WB_BIT = 21;
  localparam int SMS_BASE_HI = 19;
  localparam int SMS_BASE_LO = 16;
  localparam int SMS_SRC_HI = 15;
  localparam int SMS_SRC_LO = 12;
  localparam int SMS_IMM_HI = 11;
  localparam int SMS_SHAMT_HI = 11;
  localparam int SMS_SHAMT_LO = 7;
  localparam int SMS_SHTYP_HI = 6;
  localparam int SMS_SHTYP_LO = 5;
  localparam int SMS_RM_HI = 3;
  // status word layout: flags on top, mode in low bits
  localparam int SMS_FLAG_N = 31;
  localparam int SMS_FLAG_Z = 30;
  localparam int SMS_FLAG_C = 29;
  localparam int SMS_FLAG_V = 28;
  localparam logic [1:0] SMS_MODE_USER = 2'h0;
  localparam logic [31:0] SMS_PC_MASK = 32'h03fffffc;
  // program counter advance and word step
  localparam logic [31:0] SMS_PC_STORE_ADV = 32'h0000000c;
  localparam logic [31:0] SMS_PC_READ_ADV = 32'h00000008;
  localparam logic [31:0] SMS_WORD_STEP = 32'h00000004;
  localparam logic [3:0] SMS_PC_INDEX = 4'hf;
  // shift type codes
  localparam logic [1:0] SMS_SH_LSL = 2'h0;
  localparam logic [1:0] SMS_SH_LSR = 2'h1;
  localparam logic [1:0] SMS_SH_ASR = 2'h2;
  localparam logic [1:0] SMS_SH_ROR = 2'h3;
  // execution states
  typedef enum logic [2:0] {
    SMS_IDLE, SMS_BASE, SMS_OFFS, SMS_DATA, SMS_MEM, SMS_WBACK
  } sms_state_t;
endpackage

// ### rtl/sms_store_unit.sv
// store multiple and store single execution unit with apb status registers
`timescale 1ns/1ps
module sms_store_unit
  import sms_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // instruction issue from the core
  input wire logic iss_valid,
  output logic iss_ready,
  input wire logic [31:0] iss_instr,
  input wire logic [31:0] iss_pc,
  input wire logic [31:0] iss_psr,
  output logic iss_done,
  // register file read port, combinational data
  output logic [3:0] rf_rd_addr,
  output logic rf_rd_user,
  input wire logic [31:0] rf_rd_data,
  // register file write port for the base
  output logic rf_wr_en,
  output logic [3:0] rf_wr_addr,
  output logic [31:0] rf_wr_data,
  // memory write port
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [3:0] mem_be,
  input wire logic mem_ack,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import sms_pkg::*;

  // condition test against the flags
  function automatic logic cond_ok(input logic [3:0] c, input logic [31:0] p);
    logic n;
    logic z;
    logic cf;
    logic v;
    logic r;
    n = p[SMS_FLAG_N];
    z = p[SMS_FLAG_Z];
    cf = p[SMS_FLAG_C];
    v = p[SMS_FLAG_V];
    case (c[3:1])
      3'h0: r = z;
      3'h1: r = cf;
      3'h2: r = n;
      3'h3: r = v;
      3'h4: r = cf & ~z;
      3'h5: r = (n == v);
      3'h6: r = ~z & (n == v);
      default: r = 1'b1;
    endcase
    if (c == 4'hf) begin
      cond_ok = 1'b0;
    end else begin
      cond_ok = c[0] ? ~r : r;
    end
  endfunction

  // index of the lowest set bit of the mask
  function automatic logic [3:0] lowest_idx(input logic [15:0] m);
    lowest_idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        lowest_idx = 4'(i);
      end
    end
  endfunction

  // number of set bits, scaled to a byte length
  function automatic logic [31:0] block_bytes(input logic [15:0] m);
    logic [4:0] cnt;
    cnt = 5'h0;
    for (int i = 0; i < 16; i++) begin
      cnt = cnt + 5'(m[i]);
    end
    block_bytes = {25'h0, cnt, 2'h0};
  endfunction

  // barrel shift of the offset register
  function automatic logic [31:0] shift_ofs(input logic [31:0] v, input logic [1:0] t,
                                            input logic [4:0] a, input logic cin);
    logic [63:0] rr;
    rr = {v, v} >> a;
    case (t)
      SMS_SH_LSL: shift_ofs = v << a;
      SMS_SH_LSR: shift_ofs = (a == 5'h0) ? 32'h0 : v >> a;
      SMS_SH_ASR: shift_ofs = (a == 5'h0) ? {32{v[31]}} : 32'($signed(v) >>> a);
      default: shift_ofs = (a == 5'h0) ? {cin, v[31:1]} : rr[31:0];
    endcase
  endfunction

  // state and latched instruction
  sms_state_t state_r, state_nxt;
  logic [31:0] instr_r;
  logic [31:0] pc_r;
  logic [31:0] psr_r;
  logic [31:0] base_r; // base value as read
  logic [31:0] ofs_r; // offset magnitude
  logic [31:0] addr_r; // running transfer address
  logic [15:0] left_r; // registers still to store
  // control and statistics
  logic en_r;
  logic [31:0] exec_cnt_r;
  logic [31:0] skip_cnt_r;
  logic [31:0] prdata_r;

  // decoded fields of the latched instruction
  wire is_mult = instr_r[SMS_MULT_BIT];
  wire pre_f = instr_r[SMS_PRE_BIT];
  wire up_f = instr_r[SMS_UP_BIT];
  wire bu_f = instr_r[SMS_BYTE_USER_BIT];
  wire wb_f = instr_r[SMS_WB_BIT];
  wire [3:0] base_idx = instr_r[SMS_BASE_HI:SMS_BASE_LO];
  wire [3:0] src_idx = instr_r[SMS_SRC_HI:SMS_SRC_LO];
  wire [3:0] rm_idx = instr_r[SMS_RM_HI:0];
  wire [15:0] reg_mask = instr_r[15:0];
  wire priv = psr_r[1:0] != SMS_MODE_USER;

  // issue acceptance and condition check
  wire take = iss_valid & iss_ready;
  wire pass = cond_ok(iss_instr[SMS_COND_HI:SMS_COND_LO], iss_psr);
  assign iss_ready = (state_r == SMS_IDLE) & en_r;

  // special values when the program counter is used
  wire [31:0] pc_store_val = ((pc_r + SMS_PC_STORE_ADV) & SMS_PC_MASK) | (psr_r & ~SMS_PC_MASK);
  wire [31:0] pc_base_val = (pc_r + SMS_PC_READ_ADV) & SMS_PC_MASK;
  wire [31:0] pc_rm_val = ((pc_r + SMS_PC_READ_ADV) & SMS_PC_MASK) | (psr_r & ~SMS_PC_MASK);

  // register read port selection
  wire [3:0] cur_idx = is_mult ? lowest_idx(left_r) : src_idx;
  assign rf_rd_addr = (state_r == SMS_BASE) ? base_idx :
                      (state_r == SMS_OFFS) ? rm_idx : cur_idx;
  assign rf_rd_user = is_mult & bu_f & priv & (state_r == SMS_DATA);
  wire [31:0] store_val = (cur_idx == SMS_PC_INDEX) ? pc_store_val : rf_rd_data;
  wire [31:0] base_val = (base_idx == SMS_PC_INDEX) ? pc_base_val : rf_rd_data;
  wire [31:0] rm_val = (rm_idx == SMS_PC_INDEX) ? pc_rm_val : rf_rd_data;

  // offset from a shifted register or the immediate magnitude
  wire [31:0] rm_shifted = shift_ofs(rm_val, instr_r[SMS_SHTYP_HI:SMS_SHTYP_LO],
                                     instr_r[SMS_SHAMT_HI:SMS_SHAMT_LO],
                                     psr_r[SMS_FLAG_C]);
  wire [31:0] imm_ofs = {20'h0, instr_r[SMS_IMM_HI:0]};

  // multiple store: block length and block start address
  wire [31:0] blk_len = block_bytes(reg_mask);
  wire [31:0] blk_lo = up_f ? base_val : base_val - blk_len;
  wire [31:0] mult_start = (up_f == pre_f) ? blk_lo + SMS_WORD_STEP : blk_lo;
  wire [31:0] mult_final = up_f ? base_r + blk_len : base_r - blk_len;

  // single store: adjusted base and transfer address
  wire [31:0] adj_base = up_f ? base_r + ofs_r : base_r - ofs_r;
  wire [31:0] single_addr = pre_f ? adj_base : base_r;
  wire single_wb = ~pre_f | wb_f;

  // byte lane for a byte store
  wire [3:0] byte_lane = 4'h1 << single_addr[1:0];

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SMS_IDLE: begin
        if (take & pass) begin
          state_nxt = SMS_BASE;
        end
      end
      SMS_BASE: begin
        if (instr_r[SMS_MULT_BIT]) begin
          state_nxt = (reg_mask == 16'h0) ? SMS_WBACK : SMS_DATA;
        end else begin
          state_nxt = SMS_OFFS;
        end
      end
      SMS_OFFS: state_nxt = SMS_DATA;
      SMS_DATA: state_nxt = SMS_MEM;
      SMS_MEM: begin
        if (mem_ack) begin
          state_nxt = (is_mult && left_r != 16'h0) ? SMS_DATA : SMS_WBACK;
        end
      end
      SMS_WBACK: state_nxt = SMS_IDLE;
      default: state_nxt = SMS_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= SMS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // latch the instruction on issue
  always_ff @(posedge mclk) begin
    if (rst) begin
      instr_r <= 32'h0;
      pc_r <= 32'h0;
      psr_r <= 32'h0;
    end else if (take) begin
      instr_r <= iss_instr;
      pc_r <= iss_pc;
      psr_r <= iss_psr;
    end
  end

  // base, offset and walking address
  always_ff @(posedge mclk) begin
    if (rst) begin
      base_r <= 32'h0;
      ofs_r <= 32'h0;
      addr_r <= 32'h0;
      left_r <= 16'h0;
    end else if (state_r == SMS_BASE) begin
      base_r <= base_val;
      addr_r <= mult_start;
      left_r <= reg_mask;
      ofs_r <= imm_ofs;
    end else if (state_r == SMS_OFFS && instr_r[SMS_REGOFS_BIT]) begin
      ofs_r <= rm_shifted;
    end else if (state_r == SMS_DATA && is_mult) begin
      left_r <= left_r & ~(16'h1 << cur_idx);
    end else if (state_r == SMS_MEM && mem_ack && is_mult) begin
      addr_r <= addr_r + SMS_WORD_STEP;
    end
  end

  // memory request, held until acknowledged
  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_req <= 1'b0;
      mem_addr <= 32'h0;
      mem_wdata <= 32'h0;
      mem_be <= 4'h0;
    end else if (state_r == SMS_DATA) begin
      mem_req <= 1'b1;
      mem_addr <= is_mult ? addr_r : single_addr;
      if (!is_mult && bu_f) begin
        mem_wdata <= {4{store_val[7:0]}};
        mem_be <= byte_lane;
      end else begin
        mem_wdata <= store_val;
        mem_be <= 4'hf;
      end
    end else if (mem_ack) begin
      mem_req <= 1'b0;
    end
  end

  // base writeback and completion pulse
  always_ff @(posedge mclk) begin
    if (rst) begin
      rf_wr_en <= 1'b0;
      rf_wr_addr <= 4'h0;
      rf_wr_data <= 32'h0;
      iss_done <= 1'b0;
    end else begin
      rf_wr_en <= (state_r == SMS_WBACK) & (is_mult ? wb_f : single_wb);
      rf_wr_addr <= base_idx;
      rf_wr_data <= is_mult ? mult_final : adj_base;
      iss_done <= (state_r == SMS_WBACK) | (take & ~pass);
    end
  end

  // apb decode
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  wire hit_ctrl = paddr == SMS_CTRL_OFS;
  wire hit_any = hit_ctrl | (paddr == SMS_STAT_OFS) | (paddr == SMS_EXEC_OFS) |
                 (paddr == SMS_SKIP_OFS) | (paddr == SMS_ADDR_OFS);
  wire clr_cnt = apb_wr & hit_ctrl & pwdata[SMS_CTRL_CLR_BIT];
  assign pready = 1'b1;
  assign pslverr = apb_acc & ~hit_any;
  assign prdata = prdata_r;

  // read mux for the apb
  wire [31:0] rd_mux = hit_ctrl ? {31'h0, en_r} :
                       (paddr == SMS_STAT_OFS) ? {13'h0, left_r, state_r} :
                       (paddr == SMS_EXEC_OFS) ? exec_cnt_r :
                       (paddr == SMS_SKIP_OFS) ? skip_cnt_r :
                       (paddr == SMS_ADDR_OFS) ? mem_addr : 32'h0;

  // control register and read data
  always_ff @(posedge mclk) begin
    if (rst) begin
      en_r <= SMS_CTRL_EN_RST;
      prdata_r <= 32'h0;
    end else begin
      if (apb_wr && hit_ctrl) begin
        en_r <= pwdata[SMS_CTRL_EN_BIT];
      end
      if (psel && !penable && !pwrite) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // executed and skipped instruction counters
  always_ff @(posedge mclk) begin
    if (rst) begin
      exec_cnt_r <= 32'h0;
      skip_cnt_r <= 32'h0;
    end else begin
      if (state_r == SMS_WBACK) begin
        exec_cnt_r <= exec_cnt_r + 32'h1;
      end else if (clr_cnt) begin
        exec_cnt_r <= 32'h0;
      end
      if (take && !pass) begin
        skip_cnt_r <= skip_cnt_r + 32'h1;
      end else if (clr_cnt) begin
        skip_cnt_r <= 32'h0;
      end
    end
  end
endmodule

// ### dv/sms_mem_model.sv
// memory partner: acks held write requests and logs each word
`timescale 1ns/1ps
module sms_mem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // write port from the store unit
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] mem_be,
  output logic mem_ack,
  // wait states before each ack
  input wire logic [1:0] dly
);
  logic [31:0] log_a [64]; // logged addresses
  logic [31:0] log_d [64]; // logged data
  logic [3:0] log_b [64]; // logged lanes
  int n; // words logged
  logic [1:0] cnt_r; // wait counter
  // one ack pulse per held request, after dly waits
  always @(posedge mclk) begin
    if (rst) begin
      mem_ack <= 1'b0;
      cnt_r <= 2'h0;
      n <= 0;
    end else if (mem_req && !mem_ack && cnt_r == dly) begin
      mem_ack <= 1'b1;
      cnt_r <= 2'h0;
      log_a[n] <= mem_addr;
      log_d[n] <= mem_wdata;
      log_b[n] <= mem_be;
      n <= n + 1;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack) cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule

// ### dv/sms_store_unit_checker.sv
// port assertions for the store unit
`timescale 1ns/1ps
module sms_store_unit_checker
  import sms_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // issue side
  input wire logic iss_valid,
  input wire logic iss_ready,
  input wire logic [31:0] iss_instr,
  input wire logic [31:0] iss_psr,
  input wire logic iss_done,
  // register file side
  input wire logic rf_rd_user,
  input wire logic rf_wr_en,
  input wire logic [3:0] rf_wr_addr,
  // memory side
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] mem_be,
  input wire logic mem_ack
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [31:0] ins_r; // instruction in flight
  logic [1:0] mode_r; // its processor mode
  wire take = iss_valid && iss_ready; // issue accepted
  // keep what was taken
  always_ff @(posedge mclk) begin
    if (rst) begin
      ins_r <= 32'h0;
      mode_r <= 2'h0;
    end else if (take) begin
      ins_r <= iss_instr;
      mode_r <= iss_psr[1:0];
    end
  end
  sequence word_ack;
    mem_req && mem_ack && ins_r[SMS_MULT_BIT];
  endsequence
  sequence next_word;
    ##2 mem_req;
  endsequence
  done_pulse_a: assert property (iss_done |=> !iss_done) else $error("done longer than one cycle");
  busy_a: assert property (take |=> iss_done == iss_ready) else $error("issue taken while busy");
  done_bound_a: assert property (take |-> ##[1:200] iss_done)
    else $error("instruction never ended");
  skip_never_a: assert property (take && iss_instr[31:28] == 4'hf |=> iss_done && !mem_req)
    else $error("never condition not skipped");
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_wdata) && $stable(mem_be)) else $error("request changed before ack");
  word_step_a: assert property (word_ack ##0 next_word |-> mem_addr == $past(mem_addr, 2) + 32'h4)
    else $error("words not ascending by four");
  byte_lane_a: assert property (mem_req && mem_be != 4'hf |-> (mem_be == (4'h1 << mem_addr[1:0]))
    && (mem_wdata == {4{mem_wdata[7:0]}})) else $error("byte lane wrong");
  user_bank_a: assert property (rf_rd_user |-> ins_r[SMS_MULT_BIT] && ins_r[SMS_BYTE_USER_BIT]
    && mode_r != SMS_MODE_USER) else $error("user bank read wrongly");
  base_wb_a: assert property (rf_wr_en |-> rf_wr_addr == ins_r[19:16] && (ins_r[SMS_WB_BIT]
    || !ins_r[SMS_MULT_BIT] && !ins_r[SMS_PRE_BIT])) else $error("bad base writeback");
endmodule
bind sms_store_unit sms_store_unit_checker i_chk (.mclk, .rst, .iss_valid, .iss_ready,
  .iss_instr, .iss_psr, .iss_done, .rf_rd_user, .rf_wr_en, .rf_wr_addr, .mem_req,
  .mem_addr, .mem_wdata, .mem_be, .mem_ack);

// ### dv/sms_store_unit_test.sv
// self-checking bench for the store unit
`timescale 1ns/1ps
module sms_store_unit_test;
  import sms_pkg::*;
  logic mclk, rst, iss_valid, psel, penable, pwrite, pready, pslverr, wb_v;
  logic iss_ready, iss_done, rf_rd_user, rf_wr_en, mem_req, mem_ack;
  logic [31:0] iss_instr, iss_pc, iss_psr, pwdata, prdata, mem_addr, mem_wdata;
  logic [31:0] rf_wr_data, wb_d, q;
  logic [31:0] rf [16]; // normal bank
  logic [31:0] uf [16]; // user bank
  logic [3:0] rf_rd_addr, rf_wr_addr, mem_be;
  logic [7:0] paddr;
  logic [1:0] dly; // memory wait states
  logic e;
  int errors, n_tests, nb;
  wire [31:0] rf_rd_data = rf_rd_user ? uf[rf_rd_addr] : rf[rf_rd_addr];
  sms_store_unit i_dut (.mclk, .rst, .iss_valid, .iss_ready, .iss_instr, .iss_pc, .iss_psr,
    .iss_done, .rf_rd_addr, .rf_rd_user, .rf_rd_data, .rf_wr_en, .rf_wr_addr, .rf_wr_data,
    .mem_req, .mem_addr, .mem_wdata, .mem_be, .mem_ack, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  sms_mem_model i_mem (.mclk, .rst, .mem_req, .mem_addr, .mem_wdata, .mem_be, .mem_ack, .dly);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [31:0] x, g);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic close_out;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // apb master: setup, access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] enc(input logic [3:0] c, input logic m, r, p, u, b, w,
    input logic [3:0] rn, input logic [15:0] lo);
    return {c, m, 1'b0, r, p, u, b, w, 1'b0, rn, lo};
  endfunction
  // issue one instruction, wait for done, catch base writeback
  task automatic run(input logic [31:0] ins, p, s);
    nb = i_mem.n;
    wb_v = 1'b0;
    @(posedge mclk);
    iss_instr <= ins;
    iss_pc <= p;
    iss_psr <= s;
    iss_valid <= 1'b1;
    do @(negedge mclk); while (iss_ready !== 1'b1);
    @(posedge mclk);
    iss_valid <= 1'b0;
    for (int t = 0; t < 300; t++) begin
      @(negedge mclk);
      if (rf_wr_en === 1'b1) begin
        wb_v = 1'b1;
        wb_d = rf_wr_data;
      end
      if (iss_done === 1'b1) break;
    end
    chk("done", 32'h1, iss_done);
  endtask
  // enable reset value, disable gate, unmapped access
  task automatic t_apb;
    apb(1'b0, SMS_CTRL_OFS, 32'h0);
    chk("ctrl", 32'h1, q);
    apb(1'b1, SMS_CTRL_OFS, 32'h0);
    @(negedge mclk);
    chk("gated", 32'h0, iss_ready);
    apb(1'b1, SMS_CTRL_OFS, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h1, e);
    $display("apb done");
  endtask
  // all four modes, sparse mask with pc, slow and fast memory
  task automatic t_multi;
    logic [31:0] s, b;
    logic [31:0] ed [4];
    b = 32'h1000;
    rf[13] = b;
    ed = '{rf[0], rf[4], rf[9], ((32'h100 + SMS_PC_STORE_ADV) & SMS_PC_MASK)
      | (32'h60000003 & ~SMS_PC_MASK)};
    for (int m = 0; m < 4; m++) begin
      dly <= m[1:0];
      run(enc(4'he, 1, 0, m[1], m[0], 0, 1, 4'hd, 16'h8211), 32'h100, 32'h60000003);
      s = m[0] ? (m[1] ? b + 4 : b) : (m[1] ? b - 16 : b - 12);
      chk("words", 4, i_mem.n - nb);
      for (int k = 0; k < 4; k++) begin
        chk("addr", s + 4 * k, i_mem.log_a[nb + k]);
        chk("data", ed[k], i_mem.log_d[nb + k]);
      end
      chk("wb", m[0] ? b + 16 : b - 16, wb_d);
    end
    $display("multi done");
  endtask
  // user bank only when privileged, no writeback without flag
  task automatic t_user;
    rf[1] = 32'h3000;
    run(enc(4'he, 1, 0, 0, 1, 1, 0, 4'h1, 16'h0100), 32'h200, 32'h3);
    chk("ubank", uf[8], i_mem.log_d[nb]);
    chk("nowb", 32'h0, wb_v);
    run(enc(4'he, 1, 0, 0, 1, 1, 0, 4'h1, 16'h0100), 32'h200, 32'h0);
    chk("usrmode", rf[8], i_mem.log_d[nb]);
    $display("user done");
  endtask
  task automatic sgl(input logic [31:0] ins, a, d, input logic [3:0] be, input logic v,
    input logic [31:0] wd);
    run(ins, 32'h300, 32'h0);
    chk("s_addr", a, i_mem.log_a[nb]);
    chk("s_data", d, i_mem.log_d[nb]);
    chk("s_be", be, i_mem.log_b[nb]);
    chk("s_wbv", v, wb_v);
    if (v) chk("s_wb", wd, wb_d);
  endtask
  // word aligned stores, pc as base and offset, shifts; byte store reaches down 4095
  task automatic t_single;
    rf[2] = 32'h2001;
    rf[7] = 32'h5001;
    rf[10] = 32'h6000;
    sgl(enc(4'he, 0, 0, 1, 1, 0, 0, 4'h2, 16'h3fff), 32'h3000, rf[3], 4'hf, 0, 0);
    sgl(enc(4'he, 0, 0, 1, 0, 1, 1, 4'h7, 16'h5fff), 32'h4002, 32'h78787878, 4'h4, 1,
      32'h4002);
    sgl(enc(4'he, 0, 0, 0, 1, 0, 0, 4'ha, 16'h3010), 32'h6000, rf[3], 4'hf, 1, 32'h6010);
    sgl(enc(4'he, 0, 1, 1, 1, 0, 0, 4'ha, 16'h3106), 32'h6040, rf[3], 4'hf, 0, 0);
    sgl(enc(4'he, 0, 0, 0, 0, 0, 0, 4'hf, 16'h3008), 32'h300 + SMS_PC_READ_ADV, rf[3], 4'hf,
      1, 32'h300);
    sgl(enc(4'he, 0, 1, 1, 1, 0, 0, 4'ha, 16'h326f), 32'h80006030, rf[3], 4'hf, 0,
      0);
    sgl(enc(4'he, 0, 1, 1, 0, 0, 1, 4'ha, 16'h30a6), 32'h5ff8, rf[3], 4'hf, 1,
      32'h5ff8);
    $display("single done");
  endtask
  // never and failed equal conditions store nothing; counters read and cleared
  task automatic t_skip;
    run(enc(4'hf, 1, 0, 0, 1, 0, 1, 4'hd, 16'h00ff), 32'h400, 32'h0);
    chk("skip_nev", 0, i_mem.n - nb);
    run(enc(4'h0, 0, 0, 1, 1, 0, 1, 4'ha, 16'h3000), 32'h400, 32'h0);
    chk("skip_eq", 0, i_mem.n - nb + wb_v);
    apb(1'b0, SMS_SKIP_OFS, 32'h0);
    chk("skips", 32'h2, q);
    apb(1'b0, SMS_EXEC_OFS, 32'h0);
    chk("execs", 32'hd, q);
    apb(1'b0, SMS_ADDR_OFS, 32'h0);
    chk("last_addr", 32'h5ff8, q);
    apb(1'b1, SMS_CTRL_OFS, 32'h3);
    apb(1'b0, SMS_EXEC_OFS, 32'h0);
    chk("exec_clr", 32'h0, q);
    apb(1'b0, SMS_SKIP_OFS, 32'h0);
    chk("skip_clr", 32'h0, q);
    $display("skip done");
  endtask
  initial begin
    rst = 1'b1;
    {iss_valid, psel, penable, pwrite} = 4'h0;
    {iss_instr, iss_pc, iss_psr, pwdata} = 128'h0;
    paddr = 8'h0;
    dly = 2'h0;
    for (int i = 0; i < 16; i++) begin
      rf[i] = 32'h10000000 + i;
      uf[i] = 32'ha0000000 + i;
    end
    rf[5] = 32'h12345678;
    rf[6] = 32'h10;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_apb;
    t_multi;
    t_user;
    t_single;
    t_skip;
    close_out;
  end
  // hang guard, well beyond the expected run
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    close_out;
  end
endmodule
